// ### rtl/rcs_params.svh
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ------------------------------------------------------------
`define RCS_ADDR_W        4
`define RCS_OFF_BORCTL    4'h0
`define RCS_OFF_PWRFLAGS  4'h1
`define RCS_OFF_CPUSTAT   4'h2
`define RCS_OFF_WDTCTL    4'h3
`define RCS_OFF_CFG       4'h4
`define RCS_OFF_IRQSTAT   4'h5
`define RCS_OFF_IRQMASK   4'h6

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RCS_PF_OVF        7
`define RCS_PF_UNF        6
`define RCS_PF_PIN        3
`define RCS_PF_RSTI       2
`define RCS_PF_POR        1
`define RCS_PF_BRN        0
`define RCS_ST_TMO        4
`define RCS_ST_PDN        3
`define RCS_BC_SWEN       7
`define RCS_BC_RDY        0
`define RCS_CFG_PUT_N     0
`define RCS_CFG_STKRST    1
`define RCS_CFG_PINEN     2
`define RCS_CFG_OSTREQ    3

// ------------------------------------------------------------
// Masks and reset values
// ------------------------------------------------------------
`define RCS_PF_IMPL       8'hCF
`define RCS_ST_IMPL       8'h18
`define RCS_WDT_IMPL      8'h3F
`define RCS_BC_RST        8'h80
`define RCS_WDT_RST       8'h16
`define RCS_CFG_RST       8'h0E
`define RCS_PF_POR_VAL    8'h0C
`define RCS_PF_BRN_VAL    8'h0C
`define RCS_PF_BRN_KEEP   8'h02
`define RCS_ZERO8         8'h00
`define RCS_PC_RESET      16'h0000
`define RCS_PC_IRQVEC     16'h0004
`define RCS_PC_ONE        16'h0001

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RCS_CLK_HZ        25000000
`define RCS_PUT_MS        64
`define RCS_PUT_CYC       ((`RCS_CLK_HZ / 1000) * `RCS_PUT_MS)
`define RCS_OST_CYC       1024
`define RCS_HOLD_CYC      4
`define RCS_CNT_W         21

`endif

// ### rtl/rcs_pkg.sv
package rcs_pkg;

	// Start-up sequencer states
	typedef enum logic [3:0] {
		RCS_HOLD  = 4'b0001,
		RCS_TIMER = 4'b0010,
		RCS_PINW  = 4'b0100,
		RCS_RUN   = 4'b1000
	} rcs_state_e;

	// Interrupt event bit positions
	typedef enum logic [2:0] {
		RCS_EV_RESET = 3'd0,
		RCS_EV_WAKE  = 3'd1,
		RCS_EV_FAULT = 3'd2
	} rcs_event_e;

endpackage

// ### rtl/rcs_sequencer.sv
`timescale 1ns/1ps
`include "rcs_params.svh"
// How it works
// - Watchdog expiry resets device; timeout flag cleared, powerdown flag unchanged.
// - Reset instruction resets device and clears reset-instruction flag bit 2 only.
// - With stack fault reset enabled, overflow/underflow resets and sets bit 7/6.
// - Leaving programming mode acts like a power-on reset but keeps configuration, watchdog control and interrupt registers.
// - After power-on/brown-out, wait power-up timer, oscillator timer, pin release.
// - Timers run regardless of pin; expired timers mean start on pin release.
// - Power-up timer holds 64 ms, enabled when its active-low bit is clear.
// - Power-on: PC 0000h, timeout and powerdown set, flags 00 110x.
// - Brown-out: PC 0000h, timeout and powerdown set, flags 00 11u0.
// - Watchdog wake from sleep: PC+1, both status flags cleared.
// - Interrupt wake: timeout set, powerdown clear, next instruction, then vector 0004h if global interrupt enable set.
// - Pin reset in sleep: PC 0000h, timeout set, powerdown clear; awake unchanged.
// - Pin reset clears pin-reset flag bit 3; firmware may set it again.
// - Power-on flag bit 1 reads zero after power-on; firmware sets it.
// - Stack flags set by hardware or a firmware write, zero at power-on, firmware clears.
// - Power-control bits 5 and 4 ignore writes and read zero.
// - All resets except the two wake-ups load PC with 0000h.
// - Unimplemented status and power-control bits read zero.
module rcs_sequencer #(
	parameter int unsigned PUT_CYC  = `RCS_PUT_CYC,   // Power-up timer length in cycles
	parameter int unsigned OST_CYC  = `RCS_OST_CYC    // Oscillator start-up length in cycles
) (
	input  wire logic                   clk,            // 25 MHz system clock
	input  wire logic                   arst_n,         // Power-on reset, async, active low
	input  wire logic                   brownout_n,     // Brown-out detector, active low
	input  wire logic                   external_reset_pin_n, // External reset pin
	input  wire logic                   wdt_expired,    // Watchdog period elapsed, pulse
	input  wire logic                   reset_instr,    // Reset instruction executed, pulse
	input  wire logic                   stack_over,     // Stack overflow, pulse
	input  wire logic                   stack_under,    // Stack underflow, pulse
	input  wire logic                   prog_exit,      // Programming mode exit, pulse
	input  wire logic                   sleeping,       // Core is in Sleep
	input  wire logic                   irq_wake,       // Interrupt wake-up, pulse
	input  wire logic                   global_irq_enable, // Global interrupt enable
	input  wire logic                   brownout_ready, // Brown-out circuit ready
	input  wire logic [`RCS_ADDR_W-1:0] reg_addr,       // Register address
	input  wire logic [7:0]             reg_wdata,      // Register write data
	input  wire logic                   reg_wr,         // Write strobe
	input  wire logic                   reg_rd,         // Read strobe
	output logic      [7:0]             reg_rdata,      // Read data, cycle after strobe
	output logic                        core_reset,     // Merged internal reset, high = held
	output logic                        pc_load,        // Program counter load pulse
	output logic      [15:0]            pc_value,       // Value to load
	output logic                        pc_advance,     // Resume at next instruction pulse
	output logic                        irq_vector,     // Push return, go to vector, pulse
	output logic      [7:0]             watchdog_control, // Watchdog control register
	output logic                        sw_brownout_enable, // Software brown-out enable
	output logic                        irq             // Interrupt, level
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic pin_s1, pin_s2, bo_s1, bo_s2, rdy_s1, rdy_s2;

	// Pins come from outside the clock domain
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			bo_s1  <= 1'b1;
			bo_s2  <= 1'b1;
			rdy_s1 <= 1'b0;
			rdy_s2 <= 1'b0;
		end
		else
		begin
			pin_s1 <= external_reset_pin_n;
			pin_s2 <= pin_s1;
			bo_s1  <= brownout_n;
			bo_s2  <= bo_s1;
			rdy_s1 <= brownout_ready;
			rdy_s2 <= rdy_s1;
		end
	end

	// ------------------------------------------------------------
	// Configuration and event decode
	// ------------------------------------------------------------
	logic [7:0] cfg;
	logic       bo_prev;
	logic       pin_prev;
	logic       pin_en, stk_rst_en, put_en_n, ost_req;
	logic       ev_por, ev_brown, ev_pin, ev_wdt, ev_rsti, ev_ovf, ev_unf;
	logic       ev_wdt_wake, ev_irq_wake, ev_full, bo_active;

	assign pin_en     = cfg[`RCS_CFG_PINEN];
	assign stk_rst_en = cfg[`RCS_CFG_STKRST];
	assign put_en_n   = cfg[`RCS_CFG_PUT_N];
	assign ost_req = cfg[`RCS_CFG_OSTREQ];

	// Brown-out and pin act on their falling edges
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bo_prev  <= 1'b1;
			pin_prev <= 1'b1;
		end
		else
		begin
			bo_prev  <= bo_s2;
			pin_prev <= pin_s2;
		end
	end

	// Software brown-out enable gates the detector
	assign ev_por      = prog_exit;
	assign ev_brown    = bo_prev & ~bo_s2 & sw_brownout_enable;
	// Low supply keeps the device held, not just the falling edge
	assign bo_active   = ~bo_s2 & sw_brownout_enable;
	assign ev_pin      = pin_en & pin_prev & ~pin_s2;
	assign ev_wdt      = wdt_expired & ~sleeping;
	assign ev_wdt_wake = wdt_expired & sleeping;
	assign ev_irq_wake = irq_wake & sleeping & ~wdt_expired;
	assign ev_rsti     = reset_instr;
	assign ev_ovf      = stack_over & stk_rst_en;
	assign ev_unf      = stack_under & stk_rst_en;
	assign ev_full     = ev_por | ev_brown | ev_pin | ev_wdt | ev_rsti | ev_ovf | ev_unf;

	// ------------------------------------------------------------
	// Start-up sequencer
	// ------------------------------------------------------------
	rcs_pkg::rcs_state_e state;
	logic [`RCS_CNT_W-1:0] put_cnt;
	logic [`RCS_CNT_W-1:0] ost_cnt;
	logic [2:0]            hold_cnt;
	logic                  timers_on;
	logic                  put_done, ost_done;

	assign put_done  = (put_cnt == '0);
	assign ost_done  = (ost_cnt == '0);

	// Timers count whatever the pin does, so they can expire under it
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			put_cnt   <= '0;
			ost_cnt   <= '0;
			timers_on <= 1'b1;
		end
		else if (ev_por || bo_active || timers_on)
		begin
			put_cnt   <= put_en_n ? '0 : `RCS_CNT_W'(PUT_CYC);
			ost_cnt   <= ost_req ? `RCS_CNT_W'(OST_CYC) : '0;
			timers_on <= 1'b0;
		end
		else
		begin
			if (!put_done)
				put_cnt <= put_cnt - 1'b1;
			if (!ost_done)
				ost_cnt <= ost_cnt - 1'b1;
		end
	end

	// One merged reset, released when every condition is met
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state    <= rcs_pkg::RCS_HOLD;
			hold_cnt <= 3'(`RCS_HOLD_CYC);
		end
		else if (ev_full || bo_active)
		begin
			state    <= rcs_pkg::RCS_HOLD;
			hold_cnt <= 3'(`RCS_HOLD_CYC);
		end
		else
		begin
			case (state)
				rcs_pkg::RCS_HOLD:
				begin
					if (hold_cnt != 3'h0)
						hold_cnt <= hold_cnt - 3'h1;
					else
						state <= rcs_pkg::RCS_TIMER;
				end
				rcs_pkg::RCS_TIMER:
					if (put_done && ost_done && !timers_on)
						state <= rcs_pkg::RCS_PINW;
				rcs_pkg::RCS_PINW:
					if (!pin_en || pin_s2)
						state <= rcs_pkg::RCS_RUN;
				rcs_pkg::RCS_RUN:
					if (pin_en && !pin_s2)
						state <= rcs_pkg::RCS_PINW;
				default:
					state <= rcs_pkg::RCS_HOLD;
			endcase
		end
	end

	assign core_reset = (state != rcs_pkg::RCS_RUN);

	// ------------------------------------------------------------
	// Program counter requests
	// ------------------------------------------------------------
	logic vec_pending;

	// Full resets go to zero; wake-ups step on, interrupt vector after
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pc_load     <= 1'b1;
			pc_value    <= `RCS_PC_RESET;
			pc_advance  <= 1'b0;
			irq_vector  <= 1'b0;
			vec_pending <= 1'b0;
		end
		else
		begin
			pc_load    <= 1'b0;
			pc_advance <= 1'b0;
			irq_vector <= 1'b0;
			if (ev_full)
			begin
				pc_load     <= 1'b1;
				pc_value    <= `RCS_PC_RESET;
				vec_pending <= 1'b0;
			end
			else if (ev_wdt_wake || ev_irq_wake)
			begin
				pc_advance  <= 1'b1;
				vec_pending <= ev_irq_wake & global_irq_enable;
			end
			else if (vec_pending)
			begin
				irq_vector  <= 1'b1;
				pc_load     <= 1'b1;
				pc_value    <= `RCS_PC_IRQVEC;
				vec_pending <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic wr_pf, wr_st, wr_bc, wr_wd, wr_cfg, wr_is, wr_im;

	assign wr_pf  = reg_wr && (reg_addr == `RCS_OFF_PWRFLAGS);
	assign wr_st  = reg_wr && (reg_addr == `RCS_OFF_CPUSTAT);
	assign wr_bc  = reg_wr && (reg_addr == `RCS_OFF_BORCTL);
	assign wr_wd  = reg_wr && (reg_addr == `RCS_OFF_WDTCTL);
	assign wr_cfg = reg_wr && (reg_addr == `RCS_OFF_CFG);
	assign wr_is  = reg_wr && (reg_addr == `RCS_OFF_IRQSTAT);
	assign wr_im  = reg_wr && (reg_addr == `RCS_OFF_IRQMASK);

	// ------------------------------------------------------------
	// Power-control flags
	// ------------------------------------------------------------
	logic [7:0] power_control_flags;
	logic [7:0] next_pf;

	// Hardware events win over a firmware write in the same cycle
	always_comb
	begin
		next_pf = power_control_flags;
		if (wr_pf)
			next_pf = reg_wdata & `RCS_PF_IMPL;
		if (ev_por)
			next_pf = `RCS_PF_POR_VAL;
		else if (ev_brown)
			next_pf = `RCS_PF_BRN_VAL | (power_control_flags & `RCS_PF_BRN_KEEP);
		else
		begin
			if (ev_pin)
				next_pf[`RCS_PF_PIN] = 1'b0;
			if (ev_rsti)
				next_pf[`RCS_PF_RSTI] = 1'b0;
			if (ev_ovf)
				next_pf[`RCS_PF_OVF] = 1'b1;
			if (ev_unf)
				next_pf[`RCS_PF_UNF] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			power_control_flags <= `RCS_PF_POR_VAL;
		else
			power_control_flags <= next_pf;
	end

	// ------------------------------------------------------------
	// Status timeout and powerdown flags
	// ------------------------------------------------------------
	logic timeout_flag_n, powerdown_flag_n;

	// Flags are read only to firmware
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end
		else if (ev_por || ev_brown)
		begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end
		else if (ev_wdt_wake)
		begin
			timeout_flag_n   <= 1'b0;
			powerdown_flag_n <= 1'b0;
		end
		else if (ev_wdt)
			timeout_flag_n <= 1'b0;
		else if (ev_irq_wake || (ev_pin && sleeping))
		begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Configuration bits stand in for fuse settings
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg                <= `RCS_CFG_RST;
			watchdog_control   <= `RCS_WDT_RST;
			sw_brownout_enable <= 1'b1;
		end
		else
		begin
			if (wr_cfg)
				cfg <= reg_wdata;
			if (wr_wd)
				watchdog_control <= reg_wdata & `RCS_WDT_IMPL;
			if (ev_por)
				sw_brownout_enable <= 1'b1;
			else if (wr_bc)
				sw_brownout_enable <= reg_wdata[`RCS_BC_SWEN];
		end
	end

	// ------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------
	logic [2:0] irq_stat, irq_mask, irq_set;

	assign irq_set = {ev_ovf | ev_unf, ev_wdt_wake | ev_irq_wake, ev_full};

	// Write one to clear; a new event in the same cycle survives
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
		end
		else
		begin
			irq_stat <= (irq_stat & ~(wr_is ? reg_wdata[2:0] : 3'h0)) | irq_set;
			if (wr_im)
				irq_mask <= reg_wdata[2:0];
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Unmapped addresses and unimplemented bits read zero, except configuration bits 7:4, which read back as written
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= `RCS_ZERO8;
		else if (!reg_rd)
			reg_rdata <= `RCS_ZERO8;
		else
		begin
			case (reg_addr)
				`RCS_OFF_BORCTL:   reg_rdata <= {sw_brownout_enable, 6'h00, rdy_s2};
				`RCS_OFF_PWRFLAGS: reg_rdata <= power_control_flags & `RCS_PF_IMPL;
				`RCS_OFF_CPUSTAT:  reg_rdata <= {3'h0, timeout_flag_n, powerdown_flag_n, 3'h0};
				`RCS_OFF_WDTCTL:   reg_rdata <= watchdog_control;
				`RCS_OFF_CFG:      reg_rdata <= cfg;
				`RCS_OFF_IRQSTAT:  reg_rdata <= {5'h00, irq_stat};
				`RCS_OFF_IRQMASK:  reg_rdata <= {5'h00, irq_mask};
				default:           reg_rdata <= `RCS_ZERO8;
			endcase
		end
	end

endmodule // rcs_sequencer

// ### verif/rcs_pin_model.sv
`timescale 1ns/1ps
module rcs_pin_model (
	input wire logic        clk,        // System clock
	input wire logic        go,         // Start a low pulse
	input wire logic [7:0]  low_cycles, // Cycles to hold low
	output logic            pin_n       // Reset pin level
);
	logic [7:0] left = 8'h00;

	// Countdown of the low phase; the pin pulls up when released
	always_ff @(posedge clk)
	begin
		if (go)
			left <= low_cycles;
		else if (left != 8'h00)
			left <= left - 8'h01;
	end
	assign pin_n = (left == 8'h00);
endmodule // rcs_pin_model

// ### verif/rcs_sequencer_assertions.sv
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_sequencer_assertions (
	input wire logic        clk,                  // System clock
	input wire logic        arst_n,               // Power-on reset
	input wire logic        external_reset_pin_n, // Reset pin
	input wire logic        wdt_expired,          // Watchdog expiry
	input wire logic        reset_instr,          // Reset instruction
	input wire logic        stack_over,           // Stack overflow
	input wire logic        stack_under,          // Stack underflow
	input wire logic        sleeping,             // Core in Sleep
	input wire logic        irq_wake,             // Interrupt wake-up
	input wire logic        global_irq_enable,    // Global enable
	input wire logic [3:0]  reg_addr,             // Register address
	input wire logic        reg_wr,               // Write strobe
	input wire logic [7:0]  reg_wdata,            // Write data
	input wire logic        reg_rd,               // Read strobe
	input wire logic [7:0]  reg_rdata,            // Read data
	input wire logic        core_reset,           // Merged reset
	input wire logic        pc_load,              // PC load pulse
	input wire logic [15:0] pc_value,             // PC load value
	input wire logic        pc_advance,           // Resume pulse
	input wire logic        irq_vector            // Vector pulse
);
	// ----------------------------------------
	// One domain, so one clock and disable
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	logic stack_rst_on;

	// Mirror of the stack-fault reset enable, seen from configuration writes
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			stack_rst_on <= 1'b1;
		else if (reg_wr && reg_addr == `RCS_OFF_CFG)
			stack_rst_on <= reg_wdata[`RCS_CFG_STKRST];
	end

	AST_RI_RESET: assert property (reset_instr && !core_reset |=> core_reset && pc_load && pc_value == 16'h0000)
		else $error("reset instruction did not restart at zero");
	AST_WDT_AWAKE: assert property (wdt_expired && !sleeping && !core_reset |=> core_reset && pc_load && pc_value == 16'h0000)
		else $error("awake watchdog expiry did not reset");
	AST_STACK_RESET: assert property ((stack_over || stack_under) && stack_rst_on && !core_reset |=> core_reset && pc_load)
		else $error("stack fault did not reset");
	AST_STACK_QUIET: assert property ((stack_over || stack_under) && !stack_rst_on && !core_reset |=> !core_reset)
		else $error("disabled stack fault caused a reset");
	AST_WDT_SLEEP: assert property (wdt_expired && sleeping && !core_reset |=> pc_advance && !pc_load && !core_reset)
		else $error("sleep watchdog wake did not resume");
	AST_WAKE_VECTOR: assert property (irq_wake && sleeping && global_irq_enable && !core_reset |=> pc_advance ##1 irq_vector)
		else $error("interrupt wake did not step then vector");
	AST_VECTOR_CAUSE: assert property (irq_vector |-> $past(pc_advance))
		else $error("vector without preceding resume");
	AST_HOLD_MIN: assert property ($rose(core_reset) |-> core_reset[*4])
		else $error("merged reset shorter than hold");
	AST_PIN_RELEASE: assert property ($fell(core_reset) |-> external_reset_pin_n && $past(external_reset_pin_n))
		else $error("execution began with reset pin low");
	AST_RSV_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == `RCS_OFF_PWRFLAGS |-> reg_rdata[5:4] == 2'b00)
		else $error("unimplemented flag bits read nonzero");
	AST_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr) > 4'h6 |-> reg_rdata == 8'h00)
		else $error("unmapped read nonzero");
endmodule // rcs_sequencer_assertions

// ### verif/reset_cause_and_startup_sequencer_test.sv
`timescale 1ns/1ps
module reset_cause_and_startup_sequencer_test;
	logic        clk, arst_n, brownout_n, external_reset_pin_n, wdt_expired, reset_instr;
	logic        stack_over, stack_under, prog_exit, sleeping, irq_wake, global_irq_enable;
	logic        brownout_ready, reg_wr, reg_rd, core_reset, pc_load, pc_advance, irq_vector;
	logic        sw_brownout_enable, irq, pin_go, s_load, s_adv, s_rst, s_vec;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, watchdog_control, pin_len, pf, st, rv, va, vb;
	logic [15:0] pc_value, s_pc;
	int          err_count, tests_run, n;
	int          order[4] = '{1, 0, 2, 3};

	rcs_sequencer #(.PUT_CYC(20), .OST_CYC(8)) dut (.clk, .arst_n, .brownout_n, .external_reset_pin_n,
		.wdt_expired, .reset_instr, .stack_over, .stack_under, .prog_exit, .sleeping, .irq_wake,
		.global_irq_enable, .brownout_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.core_reset, .pc_load, .pc_value, .pc_advance, .irq_vector, .watchdog_control,
		.sw_brownout_enable, .irq);
	rcs_pin_model u_pin (.clk, .go(pin_go), .low_cycles(pin_len), .pin_n(external_reset_pin_n));

	// ----------------------------------------
	// Clock, checks and bus tasks
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Event codes: 0 watchdog, 1 reset instr, 2 overflow, 3 underflow, 4 prog exit, else wake
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: wdt_expired <= 1'b1;
			1: reset_instr <= 1'b1;
			2: stack_over <= 1'b1;
			3: stack_under <= 1'b1;
			4: prog_exit <= 1'b1;
			default: irq_wake <= 1'b1;
		endcase
		@(posedge clk);
		{wdt_expired, reset_instr, stack_over, stack_under, prog_exit, irq_wake} <= 6'h00;
		#1 {s_load, s_adv, s_rst, s_pc} = {pc_load, pc_advance, core_reset, pc_value};
		@(posedge clk);
		#1 s_vec = irq_vector;
	endtask

	// Bounded wait for the merged reset to let go
	task automatic wait_run();
		n = 0;
		while (core_reset !== 1'b0 && n < 400)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 400)
		begin
			check("core_reset release", 16'h1, 16'h0);
			final_report();
		end
	endtask

	// Expected power flags after an event (5 brown-out, 6 pin reset)
	function automatic logic [7:0] pf_next(input int k, input logic [7:0] o);
		case (k)
			1: return o & 8'hFB;
			2: return o | 8'h80;
			3: return o | 8'h40;
			4: return 8'h0C;
			5: return {6'h03, o[1], 1'b0};
			6: return o & 8'hF7;
			default: return o;
		endcase
	endfunction

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		check("run time limit", 16'h1, 16'h0);
		final_report();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{arst_n, wdt_expired, reset_instr, stack_over, stack_under, prog_exit} = 6'h00;
		{sleeping, irq_wake, global_irq_enable, reg_wr, reg_rd, pin_go} = 6'h00;
		{brownout_n, brownout_ready} = 2'b11;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		pin_len = 8'h00;
		err_count = 0;
		tests_run = 0;
		void'($urandom(32501));
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		wait_run();
		rd(4'h1, pf); check("power flags", pf, 8'h0C);
		check("power-on flag", pf[1], 1'b0);
		rd(4'h2, st); check("status", st, 8'h18);
		rd(4'h0, rv); check("brownout control", rv, 8'h81);
		rd(4'hF, rv); check("unmapped", rv, 8'h00);
		$display("power-on test done");

		wr(4'h1, 8'h3F); rd(4'h1, pf); check("flags write", pf, 8'h0F);
		wr(4'h2, 8'h00); rd(4'h2, rv); check("status write", rv, st);
		va = 8'($urandom);
		wr(4'h3, va); rd(4'h3, rv); check("watchdog control", rv, va & 8'h3F);
		check("watchdog output", watchdog_control, va & 8'h3F);
		wr(4'h0, 8'h7F); rd(4'h0, rv); check("brownout control write", rv, 8'h01);
		check("brownout enable off", sw_brownout_enable, 1'b0);
		wr(4'h0, 8'h80); check("brownout enable on", sw_brownout_enable, 1'b1);
		$display("register test done");

		// Full resets from running code, each awaited before the next
		foreach (order[i])
		begin
			pf = pf_next(order[i], pf);
			st = (order[i] == 0) ? (st & 8'hEF) : st;
			pulse(order[i]);
			check("reset held", s_rst, 1'b1);
			check("pc load", {s_load, s_pc}, 17'h10000);
			wait_run();
			rd(4'h1, rv); check("flags after event", rv, pf);
			rd(4'h2, rv); check("status after event", rv, st);
		end
		wr(4'h1, 8'h0F); rd(4'h1, pf); check("stack flags cleared", pf, 8'h0F);
		// Stack fault with its reset disabled in the configuration
		wr(4'h4, 8'h0C);
		pulse(2);
		check("stack fault ignored", {s_rst, s_load}, 2'b00);
		rd(4'h1, rv); check("stack flag untouched", rv, 8'h0F);
		wr(4'h4, 8'h0E);
		$display("reset source test done");

		// Interrupt: raise, mask both ways, clear
		rd(4'h5, rv); check("irq status", rv, 8'h05);
		wr(4'h6, 8'h00); va = {7'h00, irq};
		wr(4'h6, 8'hFF); vb = {7'h00, irq};
		check("mask effect", va ^ vb, 8'h01);
		wr(4'h5, 8'hFF); rd(4'h5, rv); check("irq cleared", rv, 8'h00);
		check("irq low", irq, 1'b0);
		$display("interrupt test done");

		sleeping <= 1'b1;
		pulse(0);
		check("sleep wdt resume", {s_adv, s_load, s_rst}, 3'b100);
		rd(4'h2, rv); check("sleep wdt status", rv, 8'h00);
		global_irq_enable <= 1'b1;
		pulse(7);
		check("wake step and vector", {s_adv, s_vec, s_rst}, 3'b110);
		rd(4'h2, rv); check("wake status", rv, 8'h10);

		// Pin reset in Sleep, held low past the hold count with timers already expired
		@(posedge clk);
		pin_len <= 8'd20 + 8'($urandom % 20);
		pin_go <= 1'b1;
		@(posedge clk);
		pin_go <= 1'b0;
		repeat (18) @(posedge clk);
		#1 check("held while pin low", core_reset, 1'b1);
		sleeping <= 1'b0;
		n = 0;
		while (external_reset_pin_n !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		while (core_reset !== 1'b0 && n < 12)
		begin
			@(posedge clk);
			#1 n++;
		end
		check("start on pin release", core_reset, 1'b0);
		rd(4'h2, rv); check("pin sleep status", rv, 8'h10);
		pf = pf_next(6, pf);
		rd(4'h1, rv); check("pin flag", rv, pf);
		wr(4'h1, 8'h0F); rd(4'h1, pf); check("pin flag rewritten", pf, 8'h0F);
		$display("sleep test done");

		@(posedge clk);
		brownout_n <= 1'b0;
		repeat (6) @(posedge clk);
		brownout_n <= 1'b1;
		repeat (3) @(posedge clk);
		wait_run();
		rd(4'h1, rv); check("brown-out flags", rv, pf_next(5, pf));
		rd(4'h2, rv); check("brown-out status", rv, 8'h18);
		wr(4'h1, 8'h0F);
		pulse(4);
		wait_run();
		rd(4'h1, rv); check("prog exit flags", rv, pf_next(4, 8'h0F));
		rd(4'h2, rv); check("prog exit status", rv, 8'h18);
		$display("brown-out and programming exit test done");
		final_report();
	end
endmodule // reset_cause_and_startup_sequencer_test

bind rcs_sequencer rcs_sequencer_assertions u_chk (.clk, .arst_n, .external_reset_pin_n, .wdt_expired,
	.reset_instr, .stack_over, .stack_under, .sleeping, .irq_wake, .global_irq_enable, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rd, .reg_rdata, .core_reset, .pc_load, .pc_value, .pc_advance, .irq_vector);
